// ===== rtl/art_defines.svh
// Constants of the auxiliary reset and trigger command block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
// What this block does
// [R1] Control code zero selects a special command
// [R2] Immediate execute raises pon, idling functions
// [R3] Immediate execute while pon active drops it
// [R4] Chip reset equals external reset, clears sysctl
// [R5] Chip reset sets pon, clears serial poll
// [R6] Chip reset clears pending end-or-identify bit
// [R7] Chip reset clears hidden registers A, B, E
// [R8] Chip reset clears poll flag, system request
// [R9] Chip reset loads internal counter with eight
// [R10] Chip reset clears both pin mode bits
// [R11] Functions stay idle until immediate execute arrives
// [R12] Finish handshake completes stalled RFD/DAC holdoff
// [R13] Trigger command pulses the trigger pin high while mode bit 1 is clear
// [R14] Trigger acts as device trigger, flag untouched
// [R15] Board software must not rely on trigger
// [R16] Decode one cycle after write; pulses last one
`ifndef ART_DEFINES_SVH
`define ART_DEFINES_SVH

`define ART_OFS_AUXCMD 8'h00
`define ART_OFS_CTRL 8'h04
`define ART_OFS_SPOLL 8'h08
`define ART_OFS_STATUS 8'h0c
`define ART_OFS_HIDDEN 8'h10

`define ART_CODE_MSB 7
`define ART_CODE_LSB 5
`define ART_COM_MSB 4
`define ART_CODE_SPECIAL 3'h0
`define ART_CODE_COUNTER 3'h1
`define ART_CODE_AUXA 3'h4
`define ART_CODE_AUXB 3'h5
`define ART_CODE_AUXE 3'h6

`define ART_CMD_PON 5'h00
`define ART_CMD_CHIP_RESET 5'h02
`define ART_CMD_FINISH 5'h03
`define ART_CMD_TRIGGER 5'h04

`define ART_COUNTER_RESET 4'h8

`define ART_CTRL_SYSCTL 0
`define ART_CTRL_REQSYS 1
`define ART_CTRL_PPFLAG 2
`define ART_CTRL_EOI 3
`define ART_CTRL_MODE0 4
`define ART_CTRL_MODE1 5

`define ART_STAT_PON 0
`define ART_STAT_DEVTRG 1
`define ART_STAT_RFD 2
`define ART_STAT_DAC 3
`define ART_STAT_HELD 4

`define ART_HID_A_LSB 0
`define ART_HID_B_LSB 8
`define ART_HID_E_LSB 16
`define ART_HID_CNT_LSB 24

`endif

// ===== rtl/art_pkg.sv
// Types of the auxiliary reset and trigger command block.
// Assumes art_defines.svh supplies the numeric constants.
package art_pkg;

  // Power-on message state: off, one-cycle pulse, held by reset
  typedef enum logic [1:0] {
    ART_PON_OFF,
    ART_PON_PULSE,
    ART_PON_HELD
  } art_pon_t;

endpackage

// ===== rtl/art_cmd_decode.sv
// Special command decoder for the auxiliary command register.
// Assumes a registered command byte with a one-cycle valid.
`timescale 1ns/100ps
`include "art_defines.svh"

module art_cmd_decode
  import art_pkg::*;
(
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_valid_i,
  output logic is_pon_o,
  output logic is_chip_reset_o,
  output logic is_finish_o,
  output logic is_trigger_o,
  output logic load_a_o,
  output logic load_b_o,
  output logic load_e_o,
  output logic load_counter_o
);

  logic [2:0] code;
  logic [4:0] com;
  logic special;

  always_comb
  begin
    code = cmd_byte_i[`ART_CODE_MSB:`ART_CODE_LSB];
    com = cmd_byte_i[`ART_COM_MSB:0];
    special = cmd_valid_i && (code == `ART_CODE_SPECIAL); // R1
    is_pon_o = special && (com == `ART_CMD_PON);
    is_chip_reset_o = special && (com == `ART_CMD_CHIP_RESET);
    is_finish_o = special && (com == `ART_CMD_FINISH);
    is_trigger_o = special && (com == `ART_CMD_TRIGGER);
    load_a_o = cmd_valid_i && (code == `ART_CODE_AUXA);
    load_b_o = cmd_valid_i && (code == `ART_CODE_AUXB);
    load_e_o = cmd_valid_i && (code == `ART_CODE_AUXE);
    load_counter_o = cmd_valid_i && (code == `ART_CODE_COUNTER);
  end

endmodule // art_cmd_decode

// ===== rtl/art_aux_cmd.sv
// Auxiliary command block: pon, chip reset, finish handshake, trigger.
// Assumes a classic Wishbone master on clk_i and an asynchronous
// external reset pin; holdoff and line3 inputs come from clk_i logic.
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "art_defines.svh"

module art_aux_cmd
  import art_pkg::*;
#(
  parameter int HID_W = 5
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_reset_i,
  input wire logic rfd_holdoff_i,
  input wire logic dac_holdoff_i,
  input wire logic dev_trigger_rx_i,
  input wire logic transceiver_ctrl_line3_i,
  output logic pon_o,
  output logic system_controller_o,
  output logic request_system_control_o,
  output logic parallel_poll_flag_o,
  output logic eoi_pending_o,
  output logic pin_mode_bit0_o,
  output logic pin_mode_bit1_o,
  output logic [7:0] serial_poll_mode_reg_o,
  output logic [HID_W-1:0] auxiliary_register_a_o,
  output logic [HID_W-1:0] auxiliary_register_b_o,
  output logic [HID_W-1:0] auxiliary_register_e_o,
  output logic [3:0] internal_counter_reg_o,
  output logic finish_handshake_cmd_o,
  output logic trigger_output_pin_o,
  output logic device_trigger_action_o,
  output logic device_trigger_flag_o
);

  // Word decode shared by read and write paths
  function automatic logic art_hit(input logic [7:0] adr, input logic [7:0] ofs);
    art_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Bus state
  logic ack;
  logic [31:0] rdata;
  logic next_ack;
  logic [31:0] next_rdata;
  logic wr_go;
  logic wr_aux;
  logic wr_ctrl;
  logic wr_spoll;
  logic wr_status;

  // Command capture
  logic [7:0] cmd_byte;
  logic cmd_valid;
  logic [7:0] next_cmd_byte;
  logic next_cmd_valid;
  logic is_pon;
  logic is_chip_reset;
  logic is_finish;
  logic is_trigger;
  logic load_a;
  logic load_b;
  logic load_e;
  logic load_counter;

  // External reset synchroniser
  logic ext_meta;
  logic ext_sync;

  // Power-on state
  art_pon_t pon_state;
  art_pon_t next_pon_state;
  logic pon;
  logic next_pon;

  // Configuration state
  logic sysctl;
  logic req_sysctl;
  logic ppflag;
  logic eoi;
  logic mode0;
  logic mode1;
  logic [7:0] spoll;
  logic [HID_W-1:0] aux_a;
  logic [HID_W-1:0] aux_b;
  logic [HID_W-1:0] aux_e;
  logic [3:0] counter;
  logic next_sysctl;
  logic next_req_sysctl;
  logic next_ppflag;
  logic next_eoi;
  logic next_mode0;
  logic next_mode1;
  logic [7:0] next_spoll;
  logic [HID_W-1:0] next_aux_a;
  logic [HID_W-1:0] next_aux_b;
  logic [HID_W-1:0] next_aux_e;
  logic [3:0] next_counter;

  // Pulse outputs and trigger flag
  logic finish;
  logic trigger_pulse;
  logic trigger_pin;
  logic trigger_action;
  logic devtrg_flag;
  logic next_finish;
  logic next_trigger_pulse;
  logic next_trigger_pin;
  logic next_trigger_action;
  logic next_devtrg_flag;
  logic reset_event;

  art_cmd_decode u_decode (
    .cmd_byte_i(cmd_byte),
    .cmd_valid_i(cmd_valid),
    .is_pon_o(is_pon),
    .is_chip_reset_o(is_chip_reset),
    .is_finish_o(is_finish),
    .is_trigger_o(is_trigger),
    .load_a_o(load_a),
    .load_b_o(load_b),
    .load_e_o(load_e),
    .load_counter_o(load_counter)
  );

  // Wishbone slave: ack one cycle after the strobe, writes land at the edge that ends the ack cycle
  always_comb
  begin
    next_ack = wb_cyc_i && wb_stb_i && !ack;
    wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0];
    wr_aux = wr_go && art_hit(wb_adr_i, `ART_OFS_AUXCMD);
    wr_ctrl = wr_go && art_hit(wb_adr_i, `ART_OFS_CTRL);
    wr_spoll = wr_go && art_hit(wb_adr_i, `ART_OFS_SPOLL);
    wr_status = wr_go && art_hit(wb_adr_i, `ART_OFS_STATUS);
    next_rdata = 32'h0000_0000;
    if (art_hit(wb_adr_i, `ART_OFS_AUXCMD))
    begin
      next_rdata[7:0] = cmd_byte;
    end
    else if (art_hit(wb_adr_i, `ART_OFS_CTRL))
    begin
      next_rdata[`ART_CTRL_SYSCTL] = sysctl;
      next_rdata[`ART_CTRL_REQSYS] = req_sysctl;
      next_rdata[`ART_CTRL_PPFLAG] = ppflag;
      next_rdata[`ART_CTRL_EOI] = eoi;
      next_rdata[`ART_CTRL_MODE0] = mode0;
      next_rdata[`ART_CTRL_MODE1] = mode1;
    end
    else if (art_hit(wb_adr_i, `ART_OFS_SPOLL))
    begin
      next_rdata[7:0] = spoll;
    end
    else if (art_hit(wb_adr_i, `ART_OFS_STATUS))
    begin
      next_rdata[`ART_STAT_PON] = pon;
      next_rdata[`ART_STAT_DEVTRG] = devtrg_flag;
      next_rdata[`ART_STAT_RFD] = rfd_holdoff_i;
      next_rdata[`ART_STAT_DAC] = dac_holdoff_i;
      next_rdata[`ART_STAT_HELD] = (pon_state == ART_PON_HELD);
    end
    else if (art_hit(wb_adr_i, `ART_OFS_HIDDEN))
    begin
      next_rdata[`ART_HID_A_LSB +: HID_W] = aux_a;
      next_rdata[`ART_HID_B_LSB +: HID_W] = aux_b;
      next_rdata[`ART_HID_E_LSB +: HID_W] = aux_e;
      next_rdata[`ART_HID_CNT_LSB +: 4] = counter;
    end
    // Unmapped words answer with zero and ignore writes
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Command byte is decoded in the cycle after the write
  always_comb
  begin
    next_cmd_byte = cmd_byte;
    next_cmd_valid = wr_aux; // R16
    if (wr_aux)
    begin
      next_cmd_byte = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_byte <= 8'h00;
      cmd_valid <= 1'b0;
    end
    else if (ce_i)
    begin
      cmd_byte <= next_cmd_byte;
      cmd_valid <= next_cmd_valid;
    end
  end

  // Pin is asynchronous to clk_i; only the second stage is used
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_meta <= ext_reset_i;
      ext_sync <= ext_meta;
    end
  end

  // Pon: reset holds it, immediate execute pulses or releases it
  always_comb
  begin
    reset_event = ext_sync || is_chip_reset;
    next_pon_state = pon_state;
    case (pon_state)
      ART_PON_OFF:
      begin
        if (reset_event)
          next_pon_state = ART_PON_HELD; // R4 R5
        else if (is_pon)
          next_pon_state = ART_PON_PULSE; // R2
      end
      ART_PON_PULSE:
      begin
        if (reset_event)
          next_pon_state = ART_PON_HELD;
        else
          next_pon_state = ART_PON_OFF; // R16
      end
      ART_PON_HELD:
      begin
        if (reset_event)
          next_pon_state = ART_PON_HELD;
        else if (is_pon)
          next_pon_state = ART_PON_OFF; // R3 R11
      end
      default:
        next_pon_state = ART_PON_HELD;
    endcase
    next_pon = (next_pon_state != ART_PON_OFF);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pon_state <= ART_PON_HELD;
      pon <= 1'b1;
    end
    else if (ce_i)
    begin
      pon_state <= next_pon_state;
      pon <= next_pon;
    end
  end

  // Configuration: software writes lose to a reset in the same cycle, except a sysctl write during a pin reset
  always_comb
  begin
    next_sysctl = sysctl;
    next_req_sysctl = req_sysctl;
    next_ppflag = ppflag;
    next_eoi = eoi;
    next_mode0 = mode0;
    next_mode1 = mode1;
    next_spoll = spoll;
    next_aux_a = aux_a;
    next_aux_b = aux_b;
    next_aux_e = aux_e;
    next_counter = counter;
    if (wr_ctrl)
    begin
      next_sysctl = wb_dat_i[`ART_CTRL_SYSCTL];
      next_req_sysctl = wb_dat_i[`ART_CTRL_REQSYS];
      next_ppflag = wb_dat_i[`ART_CTRL_PPFLAG];
      next_eoi = wb_dat_i[`ART_CTRL_EOI];
      next_mode0 = wb_dat_i[`ART_CTRL_MODE0];
      next_mode1 = wb_dat_i[`ART_CTRL_MODE1];
    end
    if (wr_spoll)
      next_spoll = wb_dat_i[7:0];
    if (load_a)
      next_aux_a = cmd_byte[HID_W-1:0];
    if (load_b)
      next_aux_b = cmd_byte[HID_W-1:0];
    if (load_e)
      next_aux_e = cmd_byte[HID_W-1:0];
    if (load_counter)
      next_counter = cmd_byte[3:0];
    if (reset_event)
    begin
      next_spoll = 8'h00; // R5
      next_eoi = 1'b0; // R6
      next_aux_a = '0; // R7
      next_aux_b = '0; // R7
      next_aux_e = '0; // R7
      next_ppflag = 1'b0; // R8
      next_req_sysctl = 1'b0; // R8
      next_counter = `ART_COUNTER_RESET; // R9
      next_mode0 = 1'b0; // R10
      next_mode1 = 1'b0; // R10
    end
    // The pin reset leaves sysctl; of the two resets only the command clears it
    if (is_chip_reset)
      next_sysctl = 1'b0; // R4
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sysctl <= 1'b0;
      req_sysctl <= 1'b0;
      ppflag <= 1'b0;
      eoi <= 1'b0;
      mode0 <= 1'b0;
      mode1 <= 1'b0;
      spoll <= 8'h00;
      aux_a <= '0;
      aux_b <= '0;
      aux_e <= '0;
      counter <= `ART_COUNTER_RESET;
    end
    else if (ce_i)
    begin
      sysctl <= next_sysctl;
      req_sysctl <= next_req_sysctl;
      ppflag <= next_ppflag;
      eoi <= next_eoi;
      mode0 <= next_mode0;
      mode1 <= next_mode1;
      spoll <= next_spoll;
      aux_a <= next_aux_a;
      aux_b <= next_aux_b;
      aux_e <= next_aux_e;
      counter <= next_counter;
    end
  end

  // Pulses and the device trigger flag; a set beats a clear
  always_comb
  begin
    next_finish = is_finish && (rfd_holdoff_i || dac_holdoff_i); // R12
    next_trigger_pulse = is_trigger; // R13 R16
    next_trigger_action = is_trigger; // R14
    // Shared pin: line3 owns it while mode bit 1 is set
    next_trigger_pin = mode1 ? transceiver_ctrl_line3_i : is_trigger; // R13
    next_devtrg_flag = devtrg_flag;
    if (wr_status && wb_dat_i[`ART_STAT_DEVTRG])
      next_devtrg_flag = 1'b0;
    if (dev_trigger_rx_i)
      next_devtrg_flag = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      finish <= 1'b0;
      trigger_pulse <= 1'b0;
      trigger_pin <= 1'b0;
      trigger_action <= 1'b0;
      devtrg_flag <= 1'b0;
    end
    else if (ce_i)
    begin
      finish <= next_finish;
      trigger_pulse <= next_trigger_pulse;
      trigger_pin <= next_trigger_pin;
      trigger_action <= next_trigger_action;
      devtrg_flag <= next_devtrg_flag;
    end
  end

  always_comb
  begin
    wb_ack_o = ack;
    wb_dat_o = rdata;
    pon_o = pon;
    system_controller_o = sysctl;
    request_system_control_o = req_sysctl;
    parallel_poll_flag_o = ppflag;
    eoi_pending_o = eoi;
    pin_mode_bit0_o = mode0;
    pin_mode_bit1_o = mode1;
    serial_poll_mode_reg_o = spoll;
    auxiliary_register_a_o = aux_a;
    auxiliary_register_b_o = aux_b;
    auxiliary_register_e_o = aux_e;
    internal_counter_reg_o = counter;
    finish_handshake_cmd_o = finish;
    trigger_output_pin_o = trigger_pin;
    device_trigger_action_o = trigger_action;
    device_trigger_flag_o = devtrg_flag;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_trigger_cmd;
    is_trigger && ce_i && !mode1;
  endsequence

  sequence s_one_pulse;
    trigger_output_pin_o ##1 (!trigger_output_pin_o && !trigger_pulse);
  endsequence

  AST_SPECIAL_DECODE: assert property ( // R1
    (wr_aux && ce_i && wb_dat_i[`ART_CODE_MSB:`ART_CODE_LSB] == `ART_CODE_SPECIAL)
      |=> (cmd_valid && cmd_byte[`ART_CODE_MSB:`ART_CODE_LSB] == `ART_CODE_SPECIAL))
    else $error("special command write not captured");

  AST_PON_PULSE: assert property ( // R2 R16
    (is_pon && pon_state == ART_PON_OFF && !reset_event && ce_i)
      |=> (pon_o ##1 (!pon_o || !$past(ce_i) || $past(reset_event))))
    else $error("immediate execute pon not a one-cycle pulse");

  AST_PON_RELEASE: assert property ( // R3
    (is_pon && pon_state == ART_PON_HELD && !reset_event && ce_i) |=> !pon_o)
    else $error("pon not released while active");

  AST_CHIP_RESET_CORE: assert property ( // R4 R5
    (is_chip_reset && ce_i) |=> (pon_o && !system_controller_o
      && serial_poll_mode_reg_o == 8'h00))
    else $error("chip reset core state wrong");

  AST_CHIP_RESET_BITS: assert property ( // R6 R8 R10
    (is_chip_reset && ce_i) |=> (!eoi_pending_o && !parallel_poll_flag_o
      && !request_system_control_o && !pin_mode_bit0_o && !pin_mode_bit1_o))
    else $error("chip reset left control bits set");

  AST_CHIP_RESET_HIDDEN: assert property ( // R7 R9
    (is_chip_reset && ce_i) |=> (auxiliary_register_a_o == '0
      && auxiliary_register_b_o == '0 && auxiliary_register_e_o == '0
      && internal_counter_reg_o == `ART_COUNTER_RESET))
    else $error("chip reset hidden registers wrong");

  AST_HELD_IDLE: assert property ( // R11
    (pon_state == ART_PON_HELD && !is_pon) |=> (pon_o && pon_state == ART_PON_HELD))
    else $error("functions released without immediate execute");

  AST_FINISH: assert property ( // R12
    (is_finish && (rfd_holdoff_i || dac_holdoff_i) && ce_i)
      |=> finish_handshake_cmd_o ##1 (!finish_handshake_cmd_o || !$past(ce_i)))
    else $error("finish handshake pulse wrong");

  AST_TRIGGER: assert property ( // R13 R16
    s_trigger_cmd ##1 ce_i |-> s_one_pulse)
    else $error("trigger pin pulse wrong");

  AST_FLAG_KEEP: assert property ( // R14
    (is_trigger && ce_i && !dev_trigger_rx_i && !wr_status)
      |=> (device_trigger_action_o && device_trigger_flag_o == $past(device_trigger_flag_o)))
    else $error("trigger command changed device trigger flag");

endmodule // art_aux_cmd

// ===== dv/art_bus_partner.sv
// Far-side model: an instrument whose handshake is held off.
// Assumes the block's clock and a synchronous active-high reset.
`timescale 1ns/100ps

module art_bus_partner
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_rfd_i,
  input wire logic stall_dac_i,
  input wire logic finish_i,
  output logic rfd_holdoff_o,
  output logic dac_holdoff_o,
  output logic line3_o
);
  // No trigger pin input: nothing on this side relies on it
  logic next_rfd;
  logic next_dac;

  always_comb
  begin
    next_rfd = rfd_holdoff_o;
    next_dac = dac_holdoff_o;
    if (finish_i)
    begin
      next_rfd = 1'b0;
      next_dac = 1'b0;
    end
    if (stall_rfd_i)
      next_rfd = 1'b1;
    if (stall_dac_i)
      next_dac = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rfd_holdoff_o <= 1'b0;
      dac_holdoff_o <= 1'b0;
      line3_o <= 1'b0;
    end
    else
    begin
      rfd_holdoff_o <= next_rfd;
      dac_holdoff_o <= next_dac;
      // Toggles so a stale pin value cannot pass
      line3_o <= ~line3_o;
    end
  end
endmodule // art_bus_partner

// ===== dv/testbench.sv
// Self-checking bench for the auxiliary command block.
// Assumes art_defines.svh offsets and a one-clock design.
`timescale 1ns/100ps
`include "art_defines.svh"

module testbench;
  import art_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic ext_reset_i = 1'b0;
  logic dev_trigger_output_pin = 1'b0;
  logic stall_rfd = 1'b0;
  logic stall_dac = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rfd, dac, line3, pon_o, sysctl, reqsys, ppflag, eoi, m0, m1, fin, pin, act, flag;
  logic [7:0] serial_poll_mode_reg;
  logic [4:0] ra, rb, re;
  logic [3:0] cnt;
  logic [31:0] q;
  int fail_count = 0;
  int samples_checked = 0;

  always #25 clk_i = ~clk_i;

  art_aux_cmd #(.HID_W(5)) art_aux_cmd_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_reset_i(ext_reset_i), .rfd_holdoff_i(rfd), .dac_holdoff_i(dac),
    .dev_trigger_rx_i(dev_trigger_output_pin), .transceiver_ctrl_line3_i(line3), .pon_o(pon_o),
    .system_controller_o(sysctl), .request_system_control_o(reqsys),
    .parallel_poll_flag_o(ppflag), .eoi_pending_o(eoi), .pin_mode_bit0_o(m0),
    .pin_mode_bit1_o(m1), .serial_poll_mode_reg_o(serial_poll_mode_reg), .auxiliary_register_a_o(ra),
    .auxiliary_register_b_o(rb), .auxiliary_register_e_o(re), .internal_counter_reg_o(cnt),
    .finish_handshake_cmd_o(fin), .trigger_output_pin_o(pin), .device_trigger_action_o(act),
    .device_trigger_flag_o(flag));

  art_bus_partner art_bus_partner_inst (.clk_i(clk_i), .rst_i(rst_i),
    .stall_rfd_i(stall_rfd), .stall_dac_i(stall_dac), .finish_i(fin),
    .rfd_holdoff_o(rfd), .dac_holdoff_o(dac), .line3_o(line3));

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check_vec(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    check_vec({31'h0, got}, {31'h0, exp}, msg);
  endtask

  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    while (n < 20)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
      n++;
    end
    if (n == 20)
    begin
      fail_count++;
      $display("CHECK FAILED %0t no bus answer", $time);
      print_verdict();
    end
    // Data and release both belong to the edge where ack was seen
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // 0 stalls rfd, 1 stalls dac, 2 is a received device trigger
  task automatic pulse(input int which);
    @(posedge clk_i);
    case (which)
      0: stall_rfd <= 1'b1;
      1: stall_dac <= 1'b1;
      default: dev_trigger_output_pin <= 1'b1;
    endcase
    @(posedge clk_i);
    stall_rfd <= 1'b0;
    stall_dac <= 1'b0;
    dev_trigger_output_pin <= 1'b0;
  endtask

  // Counts cycles high of pon, finish, trigger pin, action after a write
  task automatic count_high(output int c[4]);
    c = '{0, 0, 0, 0};
    repeat (6)
    begin
      @(negedge clk_i);
      c[0] += (pon_o === 1'b1);
      c[1] += (fin === 1'b1);
      c[2] += (pin === 1'b1);
      c[3] += (act === 1'b1);
    end
  endtask

  task automatic sc_reset_values;
    cycles(1);
    check_bit(pon_o, 1'b1, "pon after reset");
    check_vec(32'(cnt), 32'(`ART_COUNTER_RESET), "counter after reset");
    wb_xfer(1'b0, `ART_OFS_HIDDEN, 32'h0);
    check_vec(q, 32'h0800_0000, "hidden read");
    wb_xfer(1'b0, 8'h14, 32'h0);
    check_vec(q, 32'h0, "unmapped read");
  endtask

  task automatic sc_release_pon;
    int c[4];
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h00);
    cycles(3);
    check_bit(pon_o, 1'b0, "pon dropped");
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h00);
    count_high(c);
    check_vec(32'(c[0]), 32'h1, "pon pulse length");
  endtask

  task automatic sc_chip_reset;
    int c[4];
    wb_xfer(1'b1, `ART_OFS_CTRL, 32'h3f);
    wb_xfer(1'b1, `ART_OFS_SPOLL, 32'ha5);
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h9f);
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'hbf);
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'hdf);
    // Counter load code with a trigger-like low field
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h24);
    count_high(c);
    check_vec(32'(c[3]), 32'h0, "no trigger on nonzero code");
    wb_xfer(1'b0, `ART_OFS_HIDDEN, 32'h0);
    check_vec(q, 32'h041f_1f1f, "hidden loaded");
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h02);
    cycles(3);
    check_bit(pon_o, 1'b1, "pon set");
    check_bit(sysctl, 1'b0, "sysctl cleared");
    check_vec(32'(serial_poll_mode_reg), 32'h0, "serial poll cleared");
    check_bit(eoi, 1'b0, "eoi cleared");
    check_vec(32'({ra, rb, re}), 32'h0, "hidden cleared");
    check_bit(ppflag | reqsys, 1'b0, "poll flag, request cleared");
    check_vec(32'(cnt), 32'h8, "counter eight");
    check_bit(m0 | m1, 1'b0, "pin modes cleared");
    wb_xfer(1'b0, `ART_OFS_CTRL, 32'h0);
    check_vec(q, 32'h0, "ctrl read");
    cycles(10);
    check_bit(pon_o, 1'b1, "idle held");
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h00);
    cycles(3);
    check_bit(pon_o, 1'b0, "released");
  endtask

  task automatic sc_finish;
    int c[4];
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h03);
    count_high(c);
    check_vec(32'(c[1]), 32'h0, "finish without holdoff");
    pulse(0);
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h03);
    count_high(c);
    check_vec(32'(c[1]), 32'h1, "finish on rfd");
    check_bit(rfd, 1'b0, "rfd released");
    pulse(1);
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h03);
    count_high(c);
    check_vec(32'(c[1]), 32'h1, "finish on dac");
  endtask

  task automatic sc_trigger;
    int c[4];
    pulse(2);
    cycles(2);
    check_bit(flag, 1'b1, "flag set by receive");
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h04);
    count_high(c);
    check_vec(32'(c[2]), 32'h1, "trigger pin pulse");
    check_vec(32'(c[3]), 32'h1, "trigger action pulse");
    check_bit(flag, 1'b1, "flag kept");
    wb_xfer(1'b1, `ART_OFS_STATUS, 32'h02);
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h04);
    cycles(4);
    check_bit(flag, 1'b0, "flag not set");
  endtask

  task automatic sc_pin_mode;
    logic l;
    wb_xfer(1'b1, `ART_OFS_CTRL, 32'h20);
    cycles(2);
    l = line3;
    repeat (4)
    begin
      @(negedge clk_i);
      check_bit(pin, l, "pin follows line3");
      l = line3;
    end
    // Enable low must freeze the flag and the shared pin
    @(posedge clk_i);
    ce_i <= 1'b0;
    dev_trigger_output_pin <= 1'b1;
    cycles(2);
    l = pin;
    cycles(2);
    check_bit(flag, 1'b0, "flag frozen");
    check_bit(pin, l, "pin frozen");
    @(posedge clk_i);
    ce_i <= 1'b1;
    dev_trigger_output_pin <= 1'b0;
  endtask

  task automatic sc_ext_reset;
    wb_xfer(1'b1, `ART_OFS_CTRL, 32'h3f);
    @(posedge clk_i);
    ext_reset_i <= 1'b1;
    cycles(5);
    check_bit(pon_o, 1'b1, "pon by pin");
    check_bit(sysctl, 1'b1, "sysctl kept by pin");
    check_bit(m1 | eoi, 1'b0, "fields cleared by pin");
    @(posedge clk_i);
    ext_reset_i <= 1'b0;
    cycles(8);
    check_bit(pon_o, 1'b1, "idle after pin");
    wb_xfer(1'b1, `ART_OFS_AUXCMD, 32'h00);
    cycles(3);
    check_bit(pon_o, 1'b0, "released after pin");
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_reset_values();
    sc_release_pon();
    sc_chip_reset();
    sc_finish();
    sc_trigger();
    sc_pin_mode();
    sc_ext_reset();
    print_verdict();
  end
endmodule // testbench
